// ### design/padcs_regs.svh
// Purpose: timing and field constants of the peak acquisition sequencer
// Assumes: 50 MHz clock, 20 ns period
// Notes: cycle counts derive from the times in ns
`ifndef PADCS_REGS_SVH
`define PADCS_REGS_SVH
`define PADCS_CLK_PERIOD_NS 20
`define PADCS_SETTLE_NS 600
`define PADCS_CLEAR_NS 600
`define PADCS_DIGI_WIDE_NS 5700
`define PADCS_DIGI_NARROW_NS 2800
`define PADCS_SETTLE_CYC ((`PADCS_SETTLE_NS + `PADCS_CLK_PERIOD_NS - 1) / `PADCS_CLK_PERIOD_NS)
`define PADCS_CLEAR_CYC ((`PADCS_CLEAR_NS + `PADCS_CLK_PERIOD_NS - 1) / `PADCS_CLK_PERIOD_NS)
`define PADCS_DIGI_WIDE_CYC (`PADCS_DIGI_WIDE_NS / `PADCS_CLK_PERIOD_NS)
`define PADCS_DIGI_NARROW_CYC (`PADCS_DIGI_NARROW_NS / `PADCS_CLK_PERIOD_NS)
`define PADCS_SLIDE_MAX 12'hF00
`define PADCS_THR_STEP_POS 8
`define PADCS_THR_FINE_POS 1
`endif

// ### design/padcs_pkg.sv
// Purpose: types of the peak acquisition sequencer
// Assumes: nothing beyond the constants header
// Notes: states are one-hot
package padcs_pkg;
   typedef enum logic [4:0] {
      PADCS_IDLE   = 5'h01,
      PADCS_ACQ    = 5'h02,
      PADCS_SETTLE = 5'h04,
      PADCS_DIGI   = 5'h08,
      PADCS_CLEAR  = 5'h10
   } padcs_state_t;
endpackage : padcs_pkg

// ### design/padcs_filter.sv
// Purpose: acceptance check of one converted value
// Assumes: inputs are registered in the same clock domain
// Notes: combinational, one result per cycle
`timescale 1ns/10ps
`include "padcs_regs.svh"
module padcs_filter
   import padcs_pkg::*;
(
   input wire logic [11:0] raw,        // converter output before correction
   input wire logic [11:0] slide,      // sliding offset used for this conversion
   input wire logic slide_en,          // sliding correction on
   input wire logic ovf,               // converter overflow
   input wire logic [7:0] thr,         // channel low threshold
   input wire logic fine_step,         // threshold in 2-count steps
   input wire logic kill,              // channel killed
   output logic [11:0] value,          // corrected value
   output logic accept                 // value may be stored
);
   wire logic [11:0] corrected;
   wire logic slide_bad;
   wire logic [11:0] thr_coarse;
   wire logic [11:0] thr_fine;
   wire logic above;
   assign corrected = slide_en ? 12'(raw - slide) : raw;
   assign slide_bad = slide_en && (corrected > `PADCS_SLIDE_MAX);
   assign thr_coarse = {thr, 4'h0};
   assign thr_fine = {3'h0, thr, 1'h0};
   assign above = corrected >= (fine_step ? thr_fine : thr_coarse);
   assign value = corrected;
   assign accept = above && !ovf && !slide_bad && !kill;
endmodule : padcs_filter

// ### design/padcs_seq.sv
// Purpose: sequences gate, settle, digitise and clear of all peak sections
// Assumes: gate and converter results come from outside this clock domain
// Notes: one converter result pair per channel pair; memory write is a strobe
`timescale 1ns/10ps
`include "padcs_regs.svh"
// Function
// - an asserted gate in idle starts acquisition, peaks track upward.
// - charge switches close only while the common gate is active.
// - one gate serves all 32 or 16 channels.
// - after the gate ends about 600 ns settle precede digitisation.
// - held peaks are not discharged until their conversion has finished.
// - two 12-bit converters digitise all channels within 5.7 us or 2.8 us.
// - after digitisation the clear output closes every discharge switch.
// - clear lasts about 600 ns and then the sequencer is idle again.
// - a value is written only if above threshold, not overflowed and not killed.
// - the converters use sliding-scale correction.
// - the slide offset is subtracted digitally; only 0 to 3840 is valid.
// - a value passes when it is greater than or equal to its threshold.
module padcs_seq
   import padcs_pkg::*;
#(
   parameter int CHANNELS = 32
) (
   input wire logic clk,                          // 50 MHz clock
   input wire logic rst_n,                        // asynchronous reset, active low
   input wire logic gate,                         // common gate pin
   input wire logic slide_en,                     // sliding-scale correction on
   input wire logic fine_step,                    // threshold in 2-count steps
   input wire logic [11:0] conv_a,                // block A converter data
   input wire logic [11:0] conv_b,                // block B converter data
   input wire logic ovf_a,                        // block A overflow
   input wire logic ovf_b,                        // block B overflow
   input wire logic [CHANNELS*8-1:0] thr_flat,    // 8-bit thresholds per channel
   input wire logic [CHANNELS-1:0] kill_mask,     // killed channels
   output logic charge_switch,                    // closes all charge switches
   output logic discharge_switch,                 // closes all discharge switches
   output logic [$clog2(CHANNELS/2)-1:0] mux_sel, // converter mux channel index
   output logic [11:0] slide,                     // sliding offset added before conversion
   output logic busy,                             // sequencer not idle
   output logic mem_we,                           // event memory write strobe
   output logic [$clog2(CHANNELS)-1:0] mem_ch,    // channel of the stored value
   output logic [11:0] mem_data                   // stored value
);
   localparam int HALF = CHANNELS / 2;
   localparam int DIGI_CYC = (CHANNELS > 16) ? `PADCS_DIGI_WIDE_CYC : `PADCS_DIGI_NARROW_CYC;
   localparam int SLOT_CYC = DIGI_CYC / HALF;
   localparam int CW = $clog2(HALF);
   // wide enough for the longest phase load, settle and clear
   localparam int TW = 9;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   // the gate pin has no relation to clk, so it passes two flops first
   logic gate_s0;
   logic gate_s1;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gate_s0 <= 1'b0;
         gate_s1 <= 1'b0;
      end else begin
         gate_s0 <= gate;
         gate_s1 <= gate_s0;
      end
   end

   // a converter word is taken whole; safe only because the converters
   // hold it still around the sample point, a moving word may tear
   logic [25:0] conv_s0;
   logic [25:0] conv_s1;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_s0 <= 26'h0;
         conv_s1 <= 26'h0;
      end else begin
         conv_s0 <= {ovf_b, ovf_a, conv_b, conv_a};
         conv_s1 <= conv_s0;
      end
   end

   // ----------------------------------------------------------------
   // state machine
   // ----------------------------------------------------------------
   padcs_state_t state, next_state;
   logic [TW-1:0] timer;
   logic [CW-1:0] slot;
   logic half_sel;
   wire logic timer_done = (timer == TW'(0));
   wire logic slot_last = (slot == CW'(HALF - 1));

   always_comb begin
      next_state = state;
      case (state)
         PADCS_IDLE: begin
            if (gate_s1) next_state = PADCS_ACQ;
         end
         PADCS_ACQ: begin
            if (!gate_s1) next_state = PADCS_SETTLE;
         end
         PADCS_SETTLE: begin
            if (timer_done) next_state = PADCS_DIGI;
         end
         PADCS_DIGI: begin
            if (timer_done && slot_last && half_sel) next_state = PADCS_CLEAR;
         end
         PADCS_CLEAR: begin
            if (timer_done) next_state = PADCS_IDLE;
         end
         default: next_state = PADCS_IDLE;
      endcase
   end

   // one down counter times settle, digitise and clear; each ends when it reaches zero
   wire logic enter_settle = (state == PADCS_ACQ) && (next_state == PADCS_SETTLE);
   wire logic settle_end = (state == PADCS_SETTLE) && timer_done;
   wire logic digi_tick = (state == PADCS_DIGI) && timer_done;
   logic [TW-1:0] next_timer;
   logic [CW-1:0] next_slot;
   logic next_half_sel;

   always_comb begin
      next_timer = timer;
      next_slot = slot;
      next_half_sel = half_sel;
      if (enter_settle) begin
         next_timer = TW'(`PADCS_SETTLE_CYC - 1);
      end else if (settle_end) begin
         next_timer = TW'(SLOT_CYC - 1);
         next_slot = CW'(0);
         next_half_sel = 1'b0;
      end else if (digi_tick) begin
         // each slot yields two results; store block A then block B
         // the block B cycle counts as part of the next slot's period
         if (!half_sel) begin
            next_half_sel = 1'b1;
            next_timer = TW'(0);
         end else if (slot_last) begin
            next_timer = TW'(`PADCS_CLEAR_CYC - 1);
         end else begin
            next_half_sel = 1'b0;
            next_slot = slot + CW'(1);
            next_timer = TW'(SLOT_CYC - 2);
         end
      end else if (!timer_done) begin
         next_timer = timer - TW'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= PADCS_IDLE;
         timer <= TW'(0);
         slot <= CW'(0);
         half_sel <= 1'b0;
      end else begin
         state <= next_state;
         timer <= next_timer;
         slot <= next_slot;
         half_sel <= next_half_sel;
      end
   end

   // ----------------------------------------------------------------
   // acceptance of converted values
   // ----------------------------------------------------------------
   // block A carries the lower half of the channels, block B the upper half
   wire logic [$clog2(CHANNELS)-1:0] cur_ch = half_sel ? {1'b1, slot} : {1'b0, slot};
   wire logic [11:0] cur_raw = half_sel ? conv_s1[23:12] : conv_s1[11:0];
   wire logic cur_ovf = half_sel ? conv_s1[25] : conv_s1[24];
   wire logic [7:0] cur_thr = thr_flat[cur_ch*8 +: 8];
   wire logic [11:0] f_value;
   wire logic f_accept;

   padcs_filter u_filter (
      .raw(cur_raw),
      .slide(slide),
      .slide_en(slide_en),
      .ovf(cur_ovf),
      .thr(cur_thr),
      .fine_step(fine_step),
      .kill(kill_mask[cur_ch]),
      .value(f_value),
      .accept(f_accept)
   );

   wire logic sample = digi_tick;
   wire logic next_charge = (next_state == PADCS_ACQ);
   // the capacitors discharge only once the last block B word is taken,
   // so no held peak is lost before its conversion is stored
   wire logic next_discharge = (next_state == PADCS_CLEAR);
   wire logic next_busy = (next_state != PADCS_IDLE);
   wire logic next_mem_we = sample && f_accept;
   // new offset per event so equal levels land in different code ranges
   wire logic slide_step = (state == PADCS_CLEAR) && timer_done && slide_en;
   wire logic [11:0] next_slide = slide_step ? slide + 12'h001 : slide;


   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         charge_switch <= 1'b0;
         discharge_switch <= 1'b0;
         mux_sel <= CW'(0);
         slide <= 12'h000;
         busy <= 1'b0;
         mem_we <= 1'b0;
         mem_ch <= '0;
         mem_data <= 12'h000;
      end else begin
         charge_switch <= next_charge;
         discharge_switch <= next_discharge;
         mux_sel <= slot;
         busy <= next_busy;
         mem_we <= next_mem_we;
         mem_ch <= cur_ch;
         mem_data <= f_value;
         slide <= next_slide;
      end
   end
endmodule : padcs_seq

// ### testbench/padcs_seq_props.sv
// Purpose: port timing checks of the sequencer
// Assumes: CHANNELS is 16 or 32
// Notes: bound into padcs_seq
`timescale 1ns/10ps
module padcs_seq_props #(
   parameter int CHANNELS = 32
) (
   input wire logic clk, // clock
   input wire logic rst_n, // reset
   input wire logic slide_en, // slide on
   input wire logic charge_switch, // acquire
   input wire logic discharge_switch, // clear
   input wire logic busy, // not idle
   input wire logic mem_we, // store strobe
   input wire logic [11:0] mem_data // stored value
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_CHARGE_BUSY: assert property (charge_switch |-> busy && !discharge_switch)
      else $error("charge outside acquire");
   AST_IDLE_QUIET: assert property (!busy |-> !charge_switch && !discharge_switch && !mem_we)
      else $error("activity while idle");
   AST_START: assert property ($rose(busy) |-> charge_switch)
      else $error("start without acquire");
   AST_SETTLE: assert property ($fell(charge_switch) |-> (!mem_we && !discharge_switch)[*8])
      else $error("settle too short");
   AST_HOLD: assert property (discharge_switch |=> !mem_we)
      else $error("store during clear");
   AST_CLEAR_LEN: assert property ($rose(discharge_switch) |-> discharge_switch[*8])
      else $error("clear too short");
   AST_CLEAR_END: assert property ($fell(discharge_switch) |-> ##[0:1] !busy)
      else $error("no idle after clear");
   AST_DIGI_TIME: assert property ($fell(charge_switch) |-> ##[150:330] $rose(discharge_switch))
      else $error("digitisation time off");
   AST_RANGE: assert property (mem_we && slide_en |-> mem_data <= 12'hF00)
      else $error("value out of range");
   AST_REFUSE: assert property (busy && !charge_switch |=> !charge_switch)
      else $error("gate taken while busy");
endmodule : padcs_seq_props
bind padcs_seq padcs_seq_props #(.CHANNELS(CHANNELS)) u_props (.clk(clk), .rst_n(rst_n),
   .slide_en(slide_en), .charge_switch(charge_switch), .discharge_switch(discharge_switch),
   .busy(busy), .mem_we(mem_we), .mem_data(mem_data));

// ### testbench/padcs_gate_src.sv
// Purpose: trigger logic driving the common gate
// Assumes: fire is set at a falling edge
// Notes: gate rests low between pulses
`timescale 1ns/10ps
module padcs_gate_src (
   input wire logic clk, // clock
   input wire logic fire, // start a pulse
   input wire logic [7:0] len, // width in cycles
   output logic gate = 1'b0 // gate for every channel
);
   int cnt = 0;
   always @(negedge clk) begin
      if (fire && cnt == 0) cnt = len;
      else if (cnt > 0) cnt = cnt - 1;
      gate <= (cnt > 0);
   end
endmodule : padcs_gate_src

// ### testbench/padcs_seq_tb.sv
// Purpose: self-checking bench of the sequencer
// Assumes: narrow variant, slide correction on in the later events
// Notes: expected stores are queued before each gate
`timescale 1ns/10ps
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin errors++; $display("CHECK FAILED %0t %s", $time, m); end end
module padcs_seq_tb;
   localparam int CH = 16;
   localparam int HALF = CH / 2;
   logic clk = 1'b0, rst_n = 1'b0, fire = 1'b0, slide_en = 1'b0, fine_step = 1'b0, ovf_a = 1'b0, ovf_b = 1'b0;
   logic gate, charge_switch, discharge_switch, busy, mem_we;
   logic [11:0] conv_a = 12'h000, conv_b = 12'h000, mem_data, slide;
   logic [11:0] lvl_a = 12'h000, lvl_b = 12'h000, slide_exp = 12'h000;
   logic [127:0] thr_flat = '0;
   logic [15:0] kill_mask = 16'h0000;
   logic [7:0] len = 8'h04;
   logic [3:0] mem_ch;
   logic [2:0] mux_sel;
   logic [15:0] note;
   logic [15:0] exp_q[$];
   int errors = 0, tests_run = 0;
   initial forever #10 clk = ~clk;
   padcs_gate_src src (.clk(clk), .fire(fire), .len(len), .gate(gate));
   padcs_seq #(.CHANNELS(CH)) dut (.clk(clk), .rst_n(rst_n), .gate(gate), .slide_en(slide_en),
      .fine_step(fine_step), .conv_a(conv_a), .conv_b(conv_b), .ovf_a(ovf_a), .ovf_b(ovf_b),
      .thr_flat(thr_flat), .kill_mask(kill_mask), .charge_switch(charge_switch),
      .discharge_switch(discharge_switch), .mux_sel(mux_sel), .slide(slide), .busy(busy), .mem_we(mem_we),
      .mem_ch(mem_ch), .mem_data(mem_data));
   // ---------------------------------
   // scoreboard: one note per store
   // ---------------------------------
   always @(negedge clk) if (mem_we === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0, "unexpected store")
      else begin
         note = exp_q.pop_front();
         `CHK({mem_ch, mem_data}, note, "stored value")
         `CHK(mux_sel, note[14:12], "mux index")
      end
   end
   task automatic results();
      if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results
   // block A slot first, block B the cycle after
   task automatic note_event();
      logic [11:0] v;
      logic [12:0] th;
      logic [3:0] c;
      for (int s = 0; s < HALF; s++) for (int b = 0; b < 2; b++) begin
         c = 4'(b * HALF + s);
         v = b ? lvl_b : lvl_a;
         if (slide_en && v > 12'hF00) continue;
         th = fine_step ? {4'h0, thr_flat[c*8 +: 8], 1'b0} : {1'b0, thr_flat[c*8 +: 8], 4'h0};
         if (!(b ? ovf_b : ovf_a) && !kill_mask[c] && {1'b0, v} >= th) exp_q.push_back({c, v});
      end
   endtask : note_event
   task automatic wait_for(input logic want);
      int n;
      n = 0;
      while (busy !== want) begin
         @(negedge clk);
         n++;
         if (n > 600) begin
            errors++;
            results();
         end
      end
   endtask : wait_for
   initial begin
      void'($urandom(26));
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      for (int e = 0; e < 8; e++) begin
         thr_flat = {$urandom, $urandom, $urandom, $urandom} >> (e * 2);
         kill_mask = 16'($urandom);
         slide_en = e[2];
         lvl_a = 12'($urandom);
         lvl_b = (e == 4) ? 12'hF00 : (e == 5) ? 12'hF01 : 12'($urandom);
         // converters see the level plus the offset; the sequencer takes it off again
         conv_a = lvl_a + slide_exp;
         conv_b = lvl_b + slide_exp;
         fine_step = e[0];
         ovf_a = (e == 2);
         ovf_b = (e == 3);
         len = 8'(2 + $urandom % 20);
         note_event();
         fire <= 1'b1;
         @(negedge clk);
         fire <= 1'b0;
         wait_for(1'b1);
         `CHK(charge_switch, 1'b1, "acquire")
         repeat (60) @(negedge clk);
         `CHK(charge_switch, 1'b0, "charge open")
         if (e == 1) fire <= 1'b1;
         @(negedge clk);
         fire <= 1'b0;
         wait_for(1'b0);
         if (slide_en) slide_exp = slide_exp + 12'h001;
         repeat (5) @(negedge clk);
         `CHK(busy, 1'b0, "late gate ignored")
         `CHK(slide, slide_exp, "slide offset")
         `CHK(exp_q.size(), 0, "stores missing")
      end
      results();
   end
endmodule : padcs_seq_tb
